// ### include/cws_pkg.sv
// Package: register map, field positions, reset values for the waveform block
// What this block does
// - Setting auto-restart makes hardware clear flag
// - Shutdown drives A and B override levels
// - Override level ignores output polarity
// - Without auto-restart, shutdown holds until cleared
// - Clear ignored while selected shutdown high
// - Overrides hold until next input rising edge
// - Auto-restart clears flag when sources low
// - Deadband counts on selected tick enable; all logic runs from clk_i
package cws_pkg;
  localparam logic [7:0] MAIN_CTRL_OFS = 8'h00;
  localparam logic [7:0] INPUT_SEL_OFS = 8'h04;
  localparam logic [7:0] SHUTDOWN_CTRL_OFS = 8'h08;
  localparam logic [7:0] RISE_DB_OFS = 8'h0c;
  localparam logic [7:0] FALL_DB_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] PIN_DIR_OFS = 8'h1c;
  // Main control fields
  localparam int MC_EN_BIT = 7;
  localparam int MC_OEA_BIT = 0;
  localparam int MC_OEB_BIT = 1;
  localparam int MC_POLA_BIT = 2;
  localparam int MC_POLB_BIT = 3;
  localparam int MC_CLKSEL_BIT = 4;
  // Input select fields
  localparam int IS_SRC_LSB = 0;
  localparam int IS_LVLA_BIT = 4;
  localparam int IS_LVLB_BIT = 5;
  // Shutdown control fields
  localparam int SD_ASE_BIT = 7;
  localparam int SD_ARS_BIT = 6;
  localparam int SD_SRC_LSB = 0;
  localparam int NUM_SRC = 4;
  localparam int NUM_SD = 4;
  // Interrupt status bits
  localparam int IRQ_SD_BIT = 0;
  localparam int IRQ_RESUME_BIT = 1;
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] INPUT_SEL_RST = 8'h00;
  localparam logic [7:0] SHUTDOWN_CTRL_RST = 8'h80;
  localparam logic [7:0] DB_RST = 8'h00;
  localparam logic [1:0] PIN_DIR_RST = 2'h3;
endpackage : cws_pkg

// ### sim/cws_partner.sv
// Far-side model: input waveform source and shutdown sources
`timescale 1ns/1ps
`default_nettype none
module cws_partner (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic sd_i,
  input wire logic [2:0] noise_i,
  output logic [3:0] src_o,
  output logic [3:0] sd_o
);
  logic [2:0] cnt_q;
  initial src_o = 4'h0;
  initial cnt_q = 3'h0;
  // Unused sources change every cycle so no stale level looks valid
  always @(posedge clk_i)
  begin
    cnt_q <= cnt_q + 3'h1;
    src_o[3:1] <= ~src_o[3:1];
    if (!run_i)
      src_o[0] <= 1'b0;
    else if (cnt_q == 3'h7)
      src_o[0] <= ~src_o[0];
  end
  // Only bit 1 is selected; the rest carry random noise
  assign sd_o = {noise_i[2:1], sd_i, noise_i[0]};
endmodule : cws_partner
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the waveform block with shutdown
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, run = 1'b0;
  logic sd = 1'b0, alt = 1'b0, hi = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, a, aoe, b, boe, irq;
  logic [2:0] noise = 3'h0;
  logic [3:0] src, sdl;
  int bad_count = 0, checked = 0, cyc_n = 0, exp_flag = 1;
  always #25 clk = ~clk;
  cws_top dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_ack_o(ack), .src_i(src), .shutdown_i(sdl),
    .alt_clk_en_i(alt), .output_a_pin_o(a), .output_a_oe_o(aoe),
    .output_b_pin_o(b), .output_b_oe_o(boe), .irq_o(irq));
  cws_partner partner (.clk_i(clk), .run_i(run), .sd_i(sd),
    .noise_i(noise), .src_o(src), .sd_o(sdl));
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Cuts a hang short; the whole sequence needs a few hundred cycles
  always @(posedge clk)
  begin
    noise <= 3'($urandom);
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= ad;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic flag();
    bus(cws_pkg::SHUTDOWN_CTRL_OFS, 1'b0, 32'h0);
    chk({31'h0, q[cws_pkg::SD_ASE_BIT]}, 32'(exp_flag));
  endtask : flag
  task automatic pins(input logic [1:0] e);
    chk({30'h0, a, b}, {30'h0, e});
  endtask : pins
  initial
  begin
    void'($urandom(96556));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(cws_pkg::PIN_DIR_OFS, 1'b0, 32'h0);
    chk(q, 32'h3);
    flag();
    bus(cws_pkg::RISE_DB_OFS, 1'b1, 32'h0);
    bus(cws_pkg::FALL_DB_OFS, 1'b1, 32'h0);
    bus(cws_pkg::SHUTDOWN_CTRL_OFS, 1'b1, 32'h82);
    bus(cws_pkg::INPUT_SEL_OFS, 1'b1, 32'h10);
    bus(cws_pkg::IRQ_MASK_OFS, 1'b1, 32'h1);
    bus(cws_pkg::MAIN_CTRL_OFS, 1'b1, 32'h0f);
    bus(cws_pkg::MAIN_CTRL_OFS, 1'b1, 32'h8f);
    bus(cws_pkg::PIN_DIR_OFS, 1'b1, 32'h0);
    run <= 1'b1;
    repeat (8) @(posedge clk);
    pins(2'b10);
    chk({30'h0, aoe, boe}, 32'h3);
    // Clear attempt while the selected source is still high
    sd <= 1'b1;
    repeat (6) @(posedge clk);
    bus(cws_pkg::SHUTDOWN_CTRL_OFS, 1'b1, 32'h02);
    flag();
    // Already in shutdown since reset, so no entry event yet
    chk({31'h0, irq}, 32'h0);
    run <= 1'b0;
    sd <= 1'b0;
    repeat (6) @(posedge clk);
    bus(cws_pkg::MAIN_CTRL_OFS, 1'b1, 32'h83);
    bus(cws_pkg::SHUTDOWN_CTRL_OFS, 1'b1, 32'h02);
    exp_flag = 0;
    flag();
    bus(cws_pkg::IRQ_STAT_OFS, 1'b1, 32'h3);
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Waveform would give 01 here; no rising edge yet
    pins(2'b10);
    run <= 1'b1;
    repeat (40) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    pins(2'b01);
    sd <= 1'b1;
    repeat (6) @(posedge clk);
    exp_flag = 1;
    flag();
    chk({31'h0, irq}, 32'h1);
    pins(2'b10);
    bus(cws_pkg::SHUTDOWN_CTRL_OFS, 1'b1, 32'hc2);
    flag();
    sd <= 1'b0;
    repeat (6) @(posedge clk);
    exp_flag = 0;
    flag();
    // Alternate tick held low: rise deadband never expires, A stays low
    bus(cws_pkg::MAIN_CTRL_OFS, 1'b1, 32'h03);
    bus(cws_pkg::RISE_DB_OFS, 1'b1, 32'h4);
    bus(cws_pkg::MAIN_CTRL_OFS, 1'b1, 32'h93);
    run <= 1'b1;
    repeat (16) @(posedge clk);
    hi = 1'b0;
    repeat (16) @(posedge clk) hi |= a;
    chk({31'h0, hi}, 32'h0);
    alt <= 1'b1;
    hi = 1'b0;
    repeat (32) @(posedge clk) hi |= a;
    chk({31'h0, hi}, 32'h1);
    run <= 1'b0;
    bus(8'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// ### verilog/cws_deadband.sv
// Deadband delay: holds a rising edge for a programmed count
`timescale 1ns/1ps
`default_nettype none
module cws_deadband (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic in_i,
  input wire logic [5:0] delay_i,
  output logic out_o
);
  logic [5:0] cnt_q;
  wire cnt_zero = (cnt_q == 6'h00);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 6'h00;
      out_o <= 1'b0;
    end
    else if (!in_i)
    begin
      cnt_q <= delay_i;
      out_o <= 1'b0;
    end
    else if (cnt_zero)
      out_o <= 1'b1;
    else if (tick_i)
      cnt_q <= cnt_q - 6'h01;
  end
endmodule : cws_deadband
`default_nettype wire

// ### verilog/cws_top.sv
// Complementary waveform generator with auto-shutdown and restart
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cws_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [3:0] src_i,
  input wire logic [3:0] shutdown_i,
  input wire logic alt_clk_en_i,
  output logic output_a_pin_o,
  output logic output_a_oe_o,
  output logic output_b_pin_o,
  output logic output_b_oe_o,
  output logic irq_o
);
  logic [7:0] main_ctrl_reg_q;
  logic [7:0] input_select_reg_q;
  logic [7:0] shutdown_ctrl_reg_q;
  logic [7:0] rise_deadband_reg_q;
  logic [7:0] fall_deadband_reg_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] pin_direction_bits_q;
  logic [3:0] src_m_q, src_s_q;
  logic [3:0] sd_m_q, sd_s_q;
  logic alt_m_q, alt_s_q;
  logic wave_prev_q;
  logic run_q;
  logic [31:0] rd_d;

  // Pin-side inputs pass two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_m_q <= 4'h0;
      src_s_q <= 4'h0;
      sd_m_q <= 4'h0;
      sd_s_q <= 4'h0;
      alt_m_q <= 1'b0;
      alt_s_q <= 1'b0;
    end
    else
    begin
      src_m_q <= src_i;
      src_s_q <= src_m_q;
      sd_m_q <= shutdown_i;
      sd_s_q <= sd_m_q;
      alt_m_q <= alt_clk_en_i;
      alt_s_q <= alt_m_q;
    end
  end

  wire module_on_bit = main_ctrl_reg_q[cws_pkg::MC_EN_BIT];
  wire auto_restart_select = shutdown_ctrl_reg_q[cws_pkg::SD_ARS_BIT];
  wire shutdown_active_flag = shutdown_ctrl_reg_q[cws_pkg::SD_ASE_BIT];
  wire override_level_a = input_select_reg_q[cws_pkg::IS_LVLA_BIT];
  wire override_level_b = input_select_reg_q[cws_pkg::IS_LVLB_BIT];
  wire [1:0] src_sel = input_select_reg_q[1:0];
  wire [3:0] sd_sel = shutdown_ctrl_reg_q[3:0];
  wire wave = src_s_q[src_sel];
  wire wave_rise = wave && !wave_prev_q;
  wire sd_any = |(sd_s_q & sd_sel);
  // Own clock select; the alternate source is a gated enable, no 2nd domain
  wire tick = main_ctrl_reg_q[cws_pkg::MC_CLKSEL_BIT] ? alt_s_q : 1'b1;

  // Wishbone decode
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands at the edge where the master sees ack, request still held
  wire wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire wr_main = wr && (wb_adr_i == cws_pkg::MAIN_CTRL_OFS);
  wire wr_isel = wr && (wb_adr_i == cws_pkg::INPUT_SEL_OFS);
  wire wr_sd = wr && (wb_adr_i == cws_pkg::SHUTDOWN_CTRL_OFS);
  wire wr_rdb = wr && (wb_adr_i == cws_pkg::RISE_DB_OFS);
  wire wr_fdb = wr && (wb_adr_i == cws_pkg::FALL_DB_OFS);
  wire wr_ist = wr && (wb_adr_i == cws_pkg::IRQ_STAT_OFS);
  wire wr_imk = wr && (wb_adr_i == cws_pkg::IRQ_MASK_OFS);
  wire wr_dir = wr && (wb_adr_i == cws_pkg::PIN_DIR_OFS);

  // Flag control
  wire sd_set = module_on_bit && sd_any;
  wire ase_wr = wb_dat_i[cws_pkg::SD_ASE_BIT];
  wire ars_wr = wb_dat_i[cws_pkg::SD_ARS_BIT];
  // Clear blocked while a selected input is high
  wire sw_clear = wr_sd && !ase_wr && !sd_any;
  wire auto_clear = auto_restart_select && !sd_any;
  wire ase_d = sd_set ? 1'b1 :
               (wr_sd && ase_wr) ? 1'b1 :
               (sw_clear || (auto_clear && !wr_sd)) ? 1'b0 :
               (wr_sd && ars_wr && !sd_any) ? 1'b0 :
               shutdown_active_flag;
  wire [7:0] sd_reg_d = wr_sd ?
    {ase_d, wb_dat_i[6:0]} : {ase_d, shutdown_ctrl_reg_q[6:0]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_ctrl_reg_q <= cws_pkg::MAIN_CTRL_RST;
      input_select_reg_q <= cws_pkg::INPUT_SEL_RST;
      shutdown_ctrl_reg_q <= cws_pkg::SHUTDOWN_CTRL_RST;
      rise_deadband_reg_q <= cws_pkg::DB_RST;
      fall_deadband_reg_q <= cws_pkg::DB_RST;
      irq_mask_q <= 2'h0;
      pin_direction_bits_q <= cws_pkg::PIN_DIR_RST;
    end
    else
    begin
      if (wr_main)
        main_ctrl_reg_q <= wb_dat_i[7:0];
      if (wr_isel)
        input_select_reg_q <= wb_dat_i[7:0];
      shutdown_ctrl_reg_q <= sd_reg_d;
      if (wr_rdb)
        rise_deadband_reg_q <= wb_dat_i[7:0];
      if (wr_fdb)
        fall_deadband_reg_q <= wb_dat_i[7:0];
      if (wr_imk)
        irq_mask_q <= wb_dat_i[1:0];
      if (wr_dir)
        pin_direction_bits_q <= wb_dat_i[1:0];
    end
  end

  // Run restarts only on first input rising edge after flag clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
      wave_prev_q <= 1'b0;
    end
    else
    begin
      wave_prev_q <= wave;
      if (shutdown_active_flag || !module_on_bit)
        run_q <= 1'b0;
      else if (wave_rise)
        run_q <= 1'b1;
    end
  end

  // Events: entering shutdown, resuming run; set wins over clear
  wire ev_sd = sd_set && !shutdown_active_flag;
  wire ev_res = wave_rise && !run_q && !shutdown_active_flag && module_on_bit;
  wire [1:0] ev = {ev_res, ev_sd};
  wire [1:0] ist_clr = wr_ist ? wb_dat_i[1:0] : 2'h0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_q <= 2'h0;
    else
      irq_stat_q <= (irq_stat_q & ~ist_clr) | ev;
  end

  logic dba, dbb;
  cws_deadband u_db_rise (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .in_i(wave),
    .delay_i(rise_deadband_reg_q[5:0]),
    .out_o(dba)
  );
  cws_deadband u_db_fall (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .in_i(!wave),
    .delay_i(fall_deadband_reg_q[5:0]),
    .out_o(dbb)
  );

  // Polarity only on normal waveform, never on override
  wire pol_a = main_ctrl_reg_q[cws_pkg::MC_POLA_BIT];
  wire pol_b = main_ctrl_reg_q[cws_pkg::MC_POLB_BIT];
  wire oe_a = main_ctrl_reg_q[cws_pkg::MC_OEA_BIT];
  wire oe_b = main_ctrl_reg_q[cws_pkg::MC_OEB_BIT];
  wire a_d = run_q ? (dba ^ pol_a) : override_level_a;
  wire b_d = run_q ? (dbb ^ pol_b) : override_level_b;
  // Pin driven only once module on, output enabled and direction cleared
  wire a_oe_d = module_on_bit && oe_a && !pin_direction_bits_q[0];
  wire b_oe_d = module_on_bit && oe_b && !pin_direction_bits_q[1];

  assign rd_d =
    (wb_adr_i == cws_pkg::MAIN_CTRL_OFS) ? {24'h0, main_ctrl_reg_q} :
    (wb_adr_i == cws_pkg::INPUT_SEL_OFS) ? {24'h0, input_select_reg_q} :
    (wb_adr_i == cws_pkg::SHUTDOWN_CTRL_OFS) ?
      {24'h0, shutdown_ctrl_reg_q} :
    (wb_adr_i == cws_pkg::RISE_DB_OFS) ? {24'h0, rise_deadband_reg_q} :
    (wb_adr_i == cws_pkg::FALL_DB_OFS) ? {24'h0, fall_deadband_reg_q} :
    (wb_adr_i == cws_pkg::IRQ_STAT_OFS) ? {30'h0, irq_stat_q} :
    (wb_adr_i == cws_pkg::IRQ_MASK_OFS) ? {30'h0, irq_mask_q} :
    (wb_adr_i == cws_pkg::PIN_DIR_OFS) ? {30'h0, pin_direction_bits_q} :
    32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      output_a_pin_o <= 1'b0;
      output_b_pin_o <= 1'b0;
      output_a_oe_o <= 1'b0;
      output_b_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_d : 32'h0;
      output_a_pin_o <= a_d;
      output_b_pin_o <= b_d;
      output_a_oe_o <= a_oe_d;
      output_b_oe_o <= b_oe_d;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  sd_sets_flag_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (module_on_bit && sd_any) |=> shutdown_active_flag)
    else $error("shutdown input did not set flag");
  override_a_lvl_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !run_q |=> output_a_pin_o == $past(override_level_a))
    else $error("output A not at override level");
  override_b_lvl_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !run_q |=> output_b_pin_o == $past(override_level_b))
    else $error("output B not at override level");
  clear_blocked_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (shutdown_active_flag && sd_any) |=> shutdown_active_flag)
    else $error("flag cleared while shutdown input high");
  manual_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (shutdown_active_flag && !auto_restart_select && !wr_sd)
    |=> shutdown_active_flag)
    else $error("flag cleared without software");
  auto_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (auto_restart_select && !sd_any && !wr_sd)
    |=> !shutdown_active_flag)
    else $error("auto restart did not clear flag");
  resume_edge_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(run_q) |-> $past(wave_rise))
    else $error("resume without input rising edge");
  run_stops_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    shutdown_active_flag |=> !run_q)
    else $error("waveform ran during shutdown");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |(irq_stat_q & irq_mask_q) |=> irq_o)
    else $error("interrupt not raised");
endmodule : cws_top
`default_nettype wire
